//--- logic/dio_defs.svh
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH
`define DIO_MPC_START 7'h4D
`define DIO_MPC_STOP 7'h4E
`define DIO_MR_LOW 6'h12
`define DIO_MR_HIGH 6'h13
`define DIO_MR_RUNTIME 6'h17
`define DIO_CLK_PERIOD_PS 40000
`define DIO_READOUT_NS 40
`define DIO_READOUT_MIN_NCK 8
`define DIO_READOUT_CYC (((`DIO_READOUT_NS * 1000 + `DIO_CLK_PERIOD_PS - 1) / `DIO_CLK_PERIOD_PS) > `DIO_READOUT_MIN_NCK ? ((`DIO_READOUT_NS * 1000 + `DIO_CLK_PERIOD_PS - 1) / `DIO_CLK_PERIOD_PS) : `DIO_READOUT_MIN_NCK)
`define DIO_MATCH_RUN_NS 200
`define DIO_MATCH_RUN_CYC ((`DIO_MATCH_RUN_NS * 1000 + `DIO_CLK_PERIOD_PS - 1) / `DIO_CLK_PERIOD_PS)
`define DIO_CNT_MAX 16'hFFFF
`define DIO_A_CTRL 12'h000
`define DIO_A_STAT 12'h004
`define DIO_A_RUNTIME 12'h008
`define DIO_A_RESULT 12'h00C
`define DIO_A_IRQ_STAT 12'h010
`define DIO_A_IRQ_MASK 12'h014
`define DIO_CTRL_START 0
`define DIO_CTRL_STOP 1
`define DIO_CTRL_READ 2
`define DIO_IRQ_DONE 0
`define DIO_IRQ_OVF 1
`endif

//--- logic/dio_pkg.sv
package dio_pkg;
   typedef enum logic [1:0] {DIO_OP_NONE, DIO_OP_MPC, DIO_OP_MRW, DIO_OP_MRR} dio_op_t;
endpackage

//--- logic/dio_link_if.sv
`timescale 1ns/1ps
interface dio_link_if;
   dio_pkg::dio_op_t op;
   logic [6:0] opc;
   logic [5:0] ma;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;
   modport ctl (output op, output opc, output ma, output wdata, input rdata, input rvalid);
   modport dev (input op, input opc, input ma, input wdata, output rdata, output rvalid);
endinterface

//--- logic/dio_dram_osc.sv
`timescale 1ns/1ps
`include "dio_defs.svh"
module dio_dram_osc (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic OSC_TICK,
   dio_link_if.dev LINK,
   output logic RUNNING
);
   import dio_pkg::*;
   typedef struct packed {
      logic run;
      logic [15:0] cnt;
      logic [7:0] clk_cnt;
      logic [7:0] rt;
      logic [7:0] low;
      logic [7:0] high;
      logic [7:0] rd;
      logic rv;
   } dio_dev_st_t;
   dio_dev_st_t st_ff, nxt_st;
   logic stop_now;
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rv = 1'b0;
      stop_now = 1'b0;
      if (st_ff.run) begin
         if (OSC_TICK && st_ff.cnt != `DIO_CNT_MAX) begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
         end
         nxt_st.clk_cnt = st_ff.clk_cnt + 8'h01;
         if (st_ff.rt != 8'h00 && nxt_st.clk_cnt == st_ff.rt) begin
            stop_now = 1'b1;
         end
         if (LINK.op == DIO_OP_MPC && LINK.opc == `DIO_MPC_STOP) begin
            stop_now = 1'b1;
         end
      end
      if (stop_now) begin
         nxt_st.run = 1'b0;
         nxt_st.low = nxt_st.cnt[7:0];
         nxt_st.high = nxt_st.cnt[15:8];
      end
      if (LINK.op == DIO_OP_MPC && LINK.opc == `DIO_MPC_START) begin
         nxt_st.run = 1'b1;
         nxt_st.cnt = 16'h0000;
         nxt_st.clk_cnt = 8'h00; // Results untouched here
      end
      if (LINK.op == DIO_OP_MRW && LINK.ma == `DIO_MR_RUNTIME) begin
         nxt_st.rt = LINK.wdata;
      end
      if (LINK.op == DIO_OP_MRR) begin
         nxt_st.rv = 1'b1;
         case (LINK.ma)
            `DIO_MR_LOW: nxt_st.rd = st_ff.low;
            `DIO_MR_HIGH: nxt_st.rd = st_ff.high;
            `DIO_MR_RUNTIME: nxt_st.rd = st_ff.rt;
            default: nxt_st.rd = 8'h00;
         endcase
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign LINK.rdata = st_ff.rd;
   assign LINK.rvalid = st_ff.rv;
   assign RUNNING = st_ff.run;
endmodule // dio_dram_osc

//--- logic/dio_ctl.sv
`timescale 1ns/1ps
`include "dio_defs.svh"
module dio_ctl (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   dio_link_if.ctl LINK
);
   import dio_pkg::*;
   typedef enum logic [2:0] {S_IDLE, S_RUN, S_WAIT, S_RD_LO, S_RD_HI, S_RD_WAIT} dio_ctl_state_t;
   typedef struct packed {
      dio_ctl_state_t state;
      logic [7:0] rt;
      logic [15:0] result;
      logic [7:0] wcnt;
      logic busy;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      dio_op_t op;
      logic [6:0] opc;
      logic [5:0] ma;
      logic [7:0] wdata;
      logic rt_pend;
      logic [31:0] prdata;
   } dio_ctl_st_t;
   dio_ctl_st_t st_ff, nxt_st;
   logic wr, rd;
   // One decode for the register file, shared by the next-state and the bus output
   function automatic logic [31:0] reg_read(logic [11:0] a, dio_ctl_st_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `DIO_A_STAT: v = {31'h0, s.busy};
         `DIO_A_RUNTIME: v = {24'h0, s.rt};
         `DIO_A_RESULT: v = {16'h0, s.result};
         `DIO_A_IRQ_STAT: v = {30'h0, s.irq_stat};
         `DIO_A_IRQ_MASK: v = {30'h0, s.irq_mask};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction
   logic [1:0] ev;
   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && PENABLE && !PWRITE;
   always_comb begin
      nxt_st = st_ff;
      ev = 2'b00;
      nxt_st.op = DIO_OP_NONE;
      if (st_ff.rt_pend) begin
         nxt_st.op = DIO_OP_MRW;
         nxt_st.ma = `DIO_MR_RUNTIME;
         nxt_st.wdata = st_ff.rt;
         nxt_st.rt_pend = 1'b0;
      end
      case (st_ff.state)
         S_IDLE: begin
            if (wr && PADDR == `DIO_A_CTRL && PWDATA[`DIO_CTRL_START] && !st_ff.rt_pend) begin
               nxt_st.op = DIO_OP_MPC;
               nxt_st.opc = `DIO_MPC_START;
               nxt_st.wcnt = 8'h00;
               nxt_st.busy = 1'b1;
               nxt_st.state = S_RUN;
            end
         end
         S_RUN: begin
            nxt_st.wcnt = st_ff.wcnt + 8'h01;
            if (st_ff.rt != 8'h00) begin
               if (st_ff.wcnt == st_ff.rt) begin // Device stopped itself
                  nxt_st.wcnt = 8'h00;
                  nxt_st.state = S_WAIT;
               end
            end else if (wr && PADDR == `DIO_A_CTRL && PWDATA[`DIO_CTRL_STOP]) begin
               nxt_st.op = DIO_OP_MPC;
               nxt_st.opc = `DIO_MPC_STOP;
               nxt_st.wcnt = 8'h00;
               nxt_st.state = S_WAIT;
            end
         end
         S_WAIT: begin
            nxt_st.wcnt = st_ff.wcnt + 8'h01;
            if (st_ff.wcnt >= 8'(`DIO_READOUT_CYC)) begin
               nxt_st.op = DIO_OP_MRR;
               nxt_st.ma = `DIO_MR_LOW;
               nxt_st.state = S_RD_LO;
            end
         end
         S_RD_LO: begin
            if (LINK.rvalid) begin
               nxt_st.result[7:0] = LINK.rdata;
               nxt_st.op = DIO_OP_MRR;
               nxt_st.ma = `DIO_MR_HIGH;
               nxt_st.state = S_RD_HI;
            end
         end
         S_RD_HI: begin
            if (LINK.rvalid) begin
               nxt_st.result[15:8] = LINK.rdata;
               nxt_st.busy = 1'b0;
               ev[`DIO_IRQ_DONE] = 1'b1;
               ev[`DIO_IRQ_OVF] = ({LINK.rdata, st_ff.result[7:0]} == `DIO_CNT_MAX);
               nxt_st.state = S_IDLE;
            end
         end
         default: nxt_st.state = S_IDLE;
      endcase
      if (wr && PADDR == `DIO_A_RUNTIME && st_ff.state == S_IDLE) begin
         nxt_st.rt = PWDATA[7:0];
         nxt_st.rt_pend = 1'b1;
      end
      if (wr && PADDR == `DIO_A_IRQ_MASK) begin
         nxt_st.irq_mask = PWDATA[1:0];
      end
      nxt_st.prdata = 32'h0000_0000;
      if (rd) begin
         nxt_st.prdata = reg_read(PADDR, st_ff);
      end
      // Set wins over read-clear
      if (rd && PADDR == `DIO_A_IRQ_STAT) begin
         nxt_st.irq_stat = ev;
      end else begin
         nxt_st.irq_stat = st_ff.irq_stat | ev;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   // Read data taken combinationally so access completes in one cycle
   always_comb begin
      PRDATA = 32'h0000_0000;
      if (rd) begin
         PRDATA = reg_read(PADDR, st_ff);
      end
   end
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign IRQ = |(st_ff.irq_stat & st_ff.irq_mask);
   assign LINK.op = st_ff.op;
   assign LINK.opc = st_ff.opc;
   assign LINK.ma = st_ff.ma;
   assign LINK.wdata = st_ff.wdata;
endmodule // dio_ctl

//--- tb/dio_link_chk.sv
`timescale 1ns/1ps
`include "dio_defs.svh"
module dio_link_chk (
   input wire logic CLK_SYS,
   input wire logic RST,
   input dio_pkg::dio_op_t op,
   input wire logic [6:0] opc,
   input wire logic [5:0] ma,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   import dio_pkg::*;
   logic [7:0] rt_ff;
   logic is_stop;
   logic is_start;
   // Shadow of the run time as seen on the link
   always_ff @(posedge CLK_SYS) begin
      if (RST) rt_ff <= 8'h00;
      else if (op == DIO_OP_MRW && ma == `DIO_MR_RUNTIME) rt_ff <= wdata;
   end
   assign is_stop = op == DIO_OP_MPC && opc == `DIO_MPC_STOP;
   assign is_start = op == DIO_OP_MPC && opc == `DIO_MPC_START;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   a_mrr_answer: assert property (op == DIO_OP_MRR |=> rvalid)
      else $error("read answer missing");
   a_rvalid_cause: assert property (rvalid |-> $past(op) == DIO_OP_MRR)
      else $error("read answer without read");
   a_mpc_code: assert property (op == DIO_OP_MPC |-> is_stop || is_start)
      else $error("unknown command code");
   a_mrr_addr: assert property (op == DIO_OP_MRR |-> ma == `DIO_MR_LOW || ma == `DIO_MR_HIGH)
      else $error("read of wrong register");
   a_low_then_high: assert property (op == DIO_OP_MRR && ma == `DIO_MR_LOW
      |-> ##[1:20] (op == DIO_OP_MRR && ma == `DIO_MR_HIGH))
      else $error("high byte not read");
   a_readout_wait: assert property (is_stop |=> (op != DIO_OP_MRR) [*8])
      else $error("result read too early");
   a_restart_wait: assert property (is_stop |=> (!is_start) [*8])
      else $error("restart too early");
   a_no_auto_stop: assert property (is_stop |-> rt_ff == 8'h00)
      else $error("stop sent during auto stop");
   a_stop_readout: assert property (is_stop |-> ##[9:40] (op == DIO_OP_MRR))
      else $error("no readout after stop");
   a_match_run: assert property (is_start |=> (!is_stop) [*5])
      else $error("run shorter than matching minimum");
   c_start: cover property (is_start);
   c_stop: cover property (is_stop);
   c_auto: cover property (op == DIO_OP_MRW && wdata != 8'h00);
endmodule // dio_link_chk

//--- tb/dqs_interval_osc_counter_tb_top.sv
`timescale 1ns/1ps
`include "dio_defs.svh"
module dqs_interval_osc_counter_tb_top;
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, tick = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, irq, running;
   int failures = 0, n_compared = 0;
   dio_link_if link ();
   dio_ctl dio_ctl_inst (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq), .LINK(link.ctl));
   dio_dram_osc dio_dram_osc_inst (.CLK_SYS(clk_sys), .RST(rst), .OSC_TICK(tick),
      .LINK(link.dev), .RUNNING(running));
   dio_link_chk dio_link_chk_inst (.CLK_SYS(clk_sys), .RST(rst), .op(link.op), .opc(link.opc),
      .ma(link.ma), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));
   always #20 clk_sys = ~clk_sys;
   task close_out;
      if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(string n, logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task cyc(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Zero wait states today, but the wait stays so a slower slave still works
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      r = prdata;
      chk("pslverr", pslverr, 0);
      psel <= 0;
      penable <= 0;
   endtask
   task idle;
      for (int i = 0; i < 50; i++) begin
         apb(0, `DIO_A_STAT, 0);
         if (r[0] === 1'b0) break;
      end
      chk("idle", r[0], 0);
   endtask
   // Ticks only once running, so the count is exact
   task go(int k);
      apb(1, `DIO_A_CTRL, 32'h1);
      cyc(3);
      chk("running", running, 1);
      tick <= 1;
      cyc(k);
      tick <= 0;
   endtask
   task t_regs;
      apb(0, `DIO_A_IRQ_MASK, 0);
      chk("mask", r, 0);
      apb(0, `DIO_A_RUNTIME, 0);
      chk("runtime", r, 0);
      apb(0, 12'h020, 0);
      chk("unmapped", r, 0);
      apb(1, `DIO_A_IRQ_MASK, 1);
   endtask
   task t_cmd;
      go(37);
      apb(1, `DIO_A_CTRL, 32'h2);
      idle;
      chk("stopped", running, 0);
      apb(0, `DIO_A_RESULT, 0);
      chk("result", r, 37);
      chk("irq", irq, 1);
      apb(0, `DIO_A_IRQ_STAT, 0);
      chk("irq_stat", r, 1);
      cyc(1);
      chk("irq_clr", irq, 0);
      go(300);
      apb(0, `DIO_A_RESULT, 0);
      chk("held", r, 37);
      apb(1, `DIO_A_CTRL, 32'h2);
      idle;
      apb(0, `DIO_A_RESULT, 0);
      chk("redo", r, 300);
   endtask
   task t_auto;
      apb(1, `DIO_A_RUNTIME, 20);
      apb(0, `DIO_A_RUNTIME, 0);
      chk("rt", r, 20);
      go(5);
      apb(1, `DIO_A_CTRL, 32'h2);
      chk("no_stop", running, 1);
      cyc(20);
      chk("auto", running, 0);
      idle;
      apb(0, `DIO_A_RESULT, 0);
      chk("auto_res", r, 5);
      apb(1, `DIO_A_RUNTIME, 0);
   endtask
   task t_sat;
      apb(0, `DIO_A_IRQ_STAT, 0);
      go(65540);
      apb(1, `DIO_A_CTRL, 32'h2);
      idle;
      apb(0, `DIO_A_RESULT, 0);
      chk("sat", r, 32'hFFFF);
      apb(0, `DIO_A_IRQ_STAT, 0);
      chk("ovf", r, 3);
   endtask
   initial begin
      cyc(6);
      rst <= 0;
      t_regs;
      t_cmd;
      t_auto;
      t_sat;
      close_out;
   end
   initial begin
      #4000000;
      failures++;
      close_out;
   end
endmodule // dqs_interval_osc_counter_tb_top
